// file: rtl/pis_pkg.sv
// Constants for the posted interrupt entry source check block.
// Assumes a single 100 MHz clock and a plain strobe register port.
package pis_pkg;
  // Register bus widths and byte offsets.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_ENTRY0 = 8'h00;
  localparam logic [7:0] OFS_ENTRY1 = 8'h04;
  localparam logic [7:0] OFS_ENTRY2 = 8'h08;
  localparam logic [7:0] OFS_ENTRY3 = 8'h0C;
  localparam logic [7:0] OFS_HAW = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_LAST = 8'h1C;
  // Entry field positions.
  localparam int ENTRY_W = 128;
  localparam int PRESENT_BIT = 0;
  localparam int FPD_BIT = 1;
  localparam int RSV_LO_LSB = 24;
  localparam int RSV_LO_MSB = 37;
  localparam int ADDR_LO_LSB = 38;
  localparam int ADDR_LO_MSB = 63;
  localparam int SID_LSB = 64;
  localparam int SID_MSB = 79;
  localparam int SQ_LSB = 80;
  localparam int SQ_MSB = 81;
  localparam int SVT_LSB = 82;
  localparam int SVT_MSB = 83;
  localparam int RSV_HI_LSB = 84;
  localparam int RSV_HI_MSB = 95;
  localparam int ADDR_HI_LSB = 96;
  localparam int ADDR_HI_MSB = 127;
  localparam int DESC_W = 64;
  localparam int ALIGN_BITS = 6;
  localparam int HAW_W = 7;
  localparam logic [6:0] HAW_RST = 7'h40;
  // Source check encodings.
  localparam logic [1:0] SVT_NONE = 2'h0;
  localparam logic [1:0] SVT_ID = 2'h1;
  localparam logic [1:0] SVT_BUS = 2'h2;
  localparam logic [1:0] SQ_ALL = 2'h0;
  localparam logic [1:0] SQ_NO_B2 = 2'h1;
  localparam logic [1:0] SQ_NO_B12 = 2'h2;
  localparam logic [15:0] RID_MASK_ALL = 16'hFFFF;
  localparam logic [15:0] RID_MASK_NO_B2 = 16'hFFFB;
  localparam logic [15:0] RID_MASK_NO_B12 = 16'hFFF9;
  // Status, mask and last-result layout.
  localparam int STAT_W = 3;
  localparam int ST_ACCEPT = 0;
  localparam int ST_BLOCK = 1;
  localparam int ST_FAULT = 2;
  localparam int LAST_RES_LSB = 16;
endpackage

// file: rtl/pis_chk_if.sv
// Carrier between the entry check top and its source comparator.
// Assumes both ends sit in the same clock domain; it is purely wires.
`timescale 1ns/100ps
interface pis_chk_if;
  logic [15:0] source_identifier; // Source identifier field of the entry.
  logic [1:0] sq; // Qualifier field.
  logic [1:0] source_check_type; // Check type field.
  logic [15:0] rid; // Requester id of the incoming request.
  logic pass; // High when the request passes the selected check.
  logic fmt_bad; // High when a reserved check type, or a reserved qualifier under an id check, is programmed.
  modport top (output source_identifier, output sq, output source_check_type, output rid, input pass, input fmt_bad);
  modport chk (input source_identifier, input sq, input source_check_type, input rid, output pass, output fmt_bad);
endinterface

// file: rtl/pis_src_check.sv
// Requester id comparator for one remap table entry.
// Assumes the caller only trusts its answer while the entry is present.
`timescale 1ns/100ps
module pis_src_check
  import pis_pkg::*;
(
  pis_chk_if.chk chk
);
  logic [15:0] id_mask; // Bits of the id that take part in the compare.
  logic id_hit; // Masked identifier equality.
  logic sq_bad; // Qualifier holds an encoding with no defined meaning.
  logic bus_hit; // Bus number lies inside the start..end window.

  // Qualifier picks which id bits count; phantom functions hide low bits.
  always_comb begin
    id_mask = RID_MASK_ALL;
    sq_bad = 1'b0;
    unique case (chk.sq)
      SQ_ALL: id_mask = RID_MASK_ALL;
      SQ_NO_B2: id_mask = RID_MASK_NO_B2;
      SQ_NO_B12: id_mask = RID_MASK_NO_B12;
      default: sq_bad = 1'b1;
    endcase
  end

  // Compare under the mask, and the bus range with both ends included.
  always_comb begin
    id_hit = ((chk.rid ^ chk.source_identifier) & id_mask) == 16'h0000;
    bus_hit = (chk.rid[15:8] >= chk.source_identifier[15:8]) && (chk.rid[15:8] <= chk.source_identifier[7:0]);
  end

  // The check type selects the verdict; the qualifier only counts for id checks.
  always_comb begin
    chk.pass = 1'b0;
    chk.fmt_bad = 1'b0;
    unique case (chk.source_check_type)
      SVT_NONE: chk.pass = 1'b1;
      SVT_ID: begin
        chk.pass = id_hit && !sq_bad;
        chk.fmt_bad = sq_bad;
      end
      SVT_BUS: chk.pass = bus_hit;
      default: chk.fmt_bad = 1'b1;
    endcase
  end
endmodule

// file: rtl/pis_entry_check.sv
// Posted interrupt entry check: holds one remap table entry, builds the
// descriptor address and screens each request's requester id.
// Assumes requests and register strobes are synchronous to MCLK.
`timescale 1ns/100ps
module pis_entry_check
  import pis_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] BUS_ADDR,
  input wire logic [DATA_W-1:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [DATA_W-1:0] BUS_RDATA,
  input wire logic REQ_VALID,
  input wire logic [15:0] REQ_RID,
  output logic RESP_VALID,
  output logic RESP_ACCEPT,
  output logic RESP_BLOCK,
  output logic RESP_FAULT,
  output logic [DESC_W-1:0] RESP_DESC_ADDR,
  output logic IRQ
);
  // Entry storage, four words, least significant word first.
  logic [DATA_W-1:0] entry_word [4];
  logic [DATA_W-1:0] next_entry_word [4];
  // Host address width, in bits.
  logic [HAW_W-1:0] host_address_width;
  logic [HAW_W-1:0] next_haw;
  // Sticky event flags and their interrupt mask.
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] next_status;
  logic [STAT_W-1:0] mask;
  logic [STAT_W-1:0] next_mask;
  // Last screened request, for software to inspect.
  logic [15:0] last_rid;
  logic [15:0] next_last_rid;
  logic [STAT_W-1:0] last_res;
  logic [STAT_W-1:0] next_last_res;
  // Registered outputs and their next values.
  logic [DATA_W-1:0] next_rdata;
  logic next_resp_valid;
  logic next_resp_accept;
  logic next_resp_block;
  logic next_resp_fault;
  logic [DESC_W-1:0] next_desc;
  logic next_irq;

  // Decoded entry view.
  logic [ENTRY_W-1:0] entry;
  logic present;
  logic fault_report_disable;
  logic rsv_bad;
  logic [DESC_W-1:0] haw_mask;
  logic [DESC_W-1:0] desc_addr;
  logic [STAT_W-1:0] ev;
  logic [STAT_W-1:0] clr;

  pis_chk_if chk_bus ();

  // The comparator sees the identifier fields and the request id.
  pis_src_check u_check (
    .chk(chk_bus.chk)
  );

  // Flatten the entry and pull out its fields.
  always_comb begin
    entry = {entry_word[3], entry_word[2], entry_word[1], entry_word[0]};
    present = entry[PRESENT_BIT];
    // Fault reporting disable is read whatever the present flag says.
    fault_report_disable = entry[FPD_BIT];
    // Reserved bits only count while the entry is present.
    rsv_bad = present && ((|entry[RSV_HI_MSB:RSV_HI_LSB]) ||
                          (|entry[RSV_LO_MSB:RSV_LO_LSB]));
  end

  // Drive the comparator. Fields are zeroed when absent so no stale value leaks.
  always_comb begin
    chk_bus.source_identifier = present ? entry[SID_MSB:SID_LSB] : 16'h0000;
    chk_bus.sq = present ? entry[SQ_MSB:SQ_LSB] : 2'h0;
    chk_bus.source_check_type = present ? entry[SVT_MSB:SVT_LSB] : 2'h0;
    chk_bus.rid = REQ_RID;
  end

  // Bits at or above the host address width are treated as zero.
  always_comb begin
    haw_mask = '0;
    for (int i = 0; i < DESC_W; i++) begin
      haw_mask[i] = (i < int'(host_address_width));
    end
  end

  // Descriptor address: high word, low field, and a 64-byte aligned bottom.
  // The address is only built from a present entry.
  always_comb begin
    desc_addr = '0;
    if (present) begin
      desc_addr = {entry[ADDR_HI_MSB:ADDR_HI_LSB],
                   entry[ADDR_LO_MSB:ADDR_LO_LSB],
                   {ALIGN_BITS{1'b0}}} & haw_mask;
    end
  end

  // Request screening. One verdict per request, answered the next cycle.
  always_comb begin
    next_resp_valid = REQ_VALID;
    next_resp_accept = 1'b0;
    next_resp_block = 1'b0;
    next_resp_fault = 1'b0;
    next_desc = RESP_DESC_ADDR;
    if (REQ_VALID) begin
      next_desc = '0;
      if (!present) begin
        // An absent entry blocks everything.
        next_resp_block = 1'b1;
        next_resp_fault = !fault_report_disable;
      end else if (rsv_bad || chk_bus.fmt_bad || !chk_bus.pass) begin
        // Bad programming or a failed source check blocks the request.
        next_resp_block = 1'b1;
        next_resp_fault = !fault_report_disable;
      end else begin
        next_resp_accept = 1'b1;
        next_desc = desc_addr;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      RESP_VALID <= 1'b0;
      RESP_ACCEPT <= 1'b0;
      RESP_BLOCK <= 1'b0;
      RESP_FAULT <= 1'b0;
      RESP_DESC_ADDR <= '0;
    end else begin
      RESP_VALID <= next_resp_valid;
      RESP_ACCEPT <= next_resp_accept;
      RESP_BLOCK <= next_resp_block;
      RESP_FAULT <= next_resp_fault;
      RESP_DESC_ADDR <= next_desc;
    end
  end

  // Register writes. The entry, width and mask are plain storage.
  always_comb begin
    for (int w = 0; w < 4; w++) begin
      next_entry_word[w] = entry_word[w];
    end
    next_haw = host_address_width;
    next_mask = mask;
    clr = '0;
    if (BUS_WR) begin
      unique case (BUS_ADDR)
        OFS_ENTRY0: next_entry_word[0] = BUS_WDATA;
        OFS_ENTRY1: next_entry_word[1] = BUS_WDATA;
        OFS_ENTRY2: next_entry_word[2] = BUS_WDATA;
        OFS_ENTRY3: next_entry_word[3] = BUS_WDATA;
        OFS_HAW: next_haw = BUS_WDATA[HAW_W-1:0];
        OFS_STATUS: clr = BUS_WDATA[STAT_W-1:0];
        OFS_MASK: next_mask = BUS_WDATA[STAT_W-1:0];
        default: ; // Writes elsewhere are dropped.
      endcase
    end
  end

  // Sticky flags: a new event in the same cycle as its clear survives,
  // because the set is applied after the clear.
  always_comb begin
    ev = {next_resp_fault, next_resp_block, next_resp_accept};
    next_status = (status & ~clr) | ev;
    next_irq = |(next_status & next_mask);
    next_last_rid = REQ_VALID ? REQ_RID : last_rid;
    next_last_res = REQ_VALID ? ev : last_res;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      for (int w = 0; w < 4; w++) begin
        entry_word[w] <= '0;
      end
      host_address_width <= HAW_RST;
      mask <= '0;
      status <= '0;
      IRQ <= 1'b0;
      last_rid <= '0;
      last_res <= '0;
    end else begin
      for (int w = 0; w < 4; w++) begin
        entry_word[w] <= next_entry_word[w];
      end
      host_address_width <= next_haw;
      mask <= next_mask;
      status <= next_status;
      IRQ <= next_irq;
      last_rid <= next_last_rid;
      last_res <= next_last_res;
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads zero.
  always_comb begin
    next_rdata = '0;
    if (BUS_RD) begin
      unique case (BUS_ADDR)
        OFS_ENTRY0: next_rdata = entry_word[0];
        OFS_ENTRY1: next_rdata = entry_word[1];
        OFS_ENTRY2: next_rdata = entry_word[2];
        OFS_ENTRY3: next_rdata = entry_word[3];
        OFS_HAW: next_rdata[HAW_W-1:0] = host_address_width;
        OFS_STATUS: next_rdata[STAT_W-1:0] = status;
        OFS_MASK: next_rdata[STAT_W-1:0] = mask;
        OFS_LAST: next_rdata = {{(DATA_W-LAST_RES_LSB-STAT_W){1'b0}}, last_res, last_rid};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      BUS_RDATA <= '0;
    end else begin
      BUS_RDATA <= next_rdata;
    end
  end

  // Checks on the block's own outputs.
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // A request and the verdict one cycle later.
  sequence req_s;
    REQ_VALID;
  endsequence
  sequence verdict_s;
    RESP_VALID && (RESP_ACCEPT ^ RESP_BLOCK);
  endsequence

  resp_timing_a: assert property (req_s |=> verdict_s)
    else $error("request not answered in one cycle");

  absent_blocks_a: assert property (REQ_VALID && !present |=> RESP_BLOCK)
    else $error("absent entry did not block");

  addr_align_a: assert property (RESP_VALID |-> RESP_DESC_ADDR[ALIGN_BITS-1:0] == '0)
    else $error("descriptor address not aligned");

  addr_high_a: assert property (REQ_VALID && present && host_address_width == HAW_RST && !RESP_BLOCK ##0
      next_resp_accept |=> RESP_DESC_ADDR[DESC_W-1:DATA_W] == $past(entry_word[3]))
    else $error("descriptor high word wrong");

  haw_mask_a: assert property (RESP_VALID |-> (RESP_DESC_ADDR & ~$past(haw_mask)) == '0)
    else $error("address bit above host width set");

  no_check_a: assert property (REQ_VALID && present && !rsv_bad &&
      entry[SVT_MSB:SVT_LSB] == SVT_NONE |=> RESP_ACCEPT)
    else $error("type 00b request not accepted");

  exact_id_a: assert property (REQ_VALID && present && entry[SVT_MSB:SVT_LSB] == SVT_ID &&
      entry[SQ_MSB:SQ_LSB] == SQ_ALL && REQ_RID != entry[SID_MSB:SID_LSB] |=> RESP_BLOCK)
    else $error("id mismatch accepted");

  bus_range_a: assert property (REQ_VALID && present && entry[SVT_MSB:SVT_LSB] == SVT_BUS &&
      REQ_RID[15:8] > entry[SID_MSB-8:SID_LSB] |=> RESP_BLOCK)
    else $error("bus above end accepted");

  fpd_quiet_a: assert property (REQ_VALID && fault_report_disable |=> !RESP_FAULT)
    else $error("fault raised with reporting disabled");

  fault_sticky_a: assert property (RESP_FAULT |-> status[ST_FAULT])
    else $error("fault not recorded in status");

  // Reserved bits set in a present entry must block, never accept.
  rsv_block_a: assert property (REQ_VALID && rsv_bad |=> RESP_BLOCK && !RESP_ACCEPT)
    else $error("reserved bits set but not blocked");
endmodule

// file: verification/pis_req_src.sv
// Request source model: the device side that raises interrupt requests.
// Assumes the bench asks for a request one cycle ahead through go and go_rid.
`timescale 1ns/100ps
module pis_req_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] go_rid,
  output logic req_valid,
  output logic [15:0] req_rid
);
  // Quiet lines at time zero, before the first edge.
  initial begin
    req_valid = 1'b0;
    req_rid = 16'h0000;
  end
  // Between requests the id lines flip to the inverse of their value every cycle, so a
  // design that samples a stale id one cycle late cannot match by luck.
  always @(posedge clk) begin
    req_valid <= go;
    req_rid <= go ? go_rid : ~req_rid;
  end
endmodule

// file: verification/pis_entry_check_tb_top.sv
// Self-checking bench for the posted interrupt entry check block.
// Assumes pis_pkg, the design top and the request source model are compiled.
`timescale 1ns/100ps
module pis_entry_check_tb_top
  import pis_pkg::*;
;
  logic mclk, sys_rst, bus_wr, bus_rd, go, req_valid, irq;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata;
  logic [15:0] go_rid, req_rid;
  logic resp_valid, resp_accept, resp_block, resp_fault;
  logic [DESC_W-1:0] resp_desc;
  logic [31:0] lfsr; // Random source, fixed start.
  logic [127:0] ent; // Entry as last written.
  logic [6:0] host_address_width; // Host width as last written.
  logic [127:0] rnd;
  int err_total, n_checks;

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  pis_entry_check i_dut (.MCLK(mclk), .SYS_RST(sys_rst), .BUS_ADDR(bus_addr),
    .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata),
    .REQ_VALID(req_valid), .REQ_RID(req_rid), .RESP_VALID(resp_valid),
    .RESP_ACCEPT(resp_accept), .RESP_BLOCK(resp_block), .RESP_FAULT(resp_fault),
    .RESP_DESC_ADDR(resp_desc), .IRQ(irq));
  pis_req_src i_src (.clk(mclk), .go(go), .go_rid(go_rid), .req_valid(req_valid),
    .req_rid(req_rid));

  // Next value of the 32-bit shift register.
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected {accept, block, fault, descriptor address} for one request.
  function automatic logic [66:0] exp_resp(input logic [127:0] e, input logic [6:0] w,
                                           input logic [15:0] r);
    logic ok;
    logic [15:0] m;
    logic [63:0] d;
    m = 16'hFFFF;
    if (e[81:80] == 2'h1) m = 16'hFFFB;
    if (e[81:80] == 2'h2) m = 16'hFFF9;
    case (e[83:82])
      2'h1: ok = (e[81:80] != 2'h3) && ((e[79:64] & m) == (r & m));
      2'h2: ok = (r[15:8] >= e[79:72]) && (r[15:8] <= e[71:64]);
      2'h3: ok = 1'b0;
      default: ok = 1'b1;
    endcase
    // Absent entries and nonzero reserved bits always block.
    ok = ok && e[0] && (e[95:84] == 12'h000) && (e[37:24] == 14'h0000);
    d = {e[127:96], e[63:38], 6'h00};
    if (w < 7'h40) d = d & ((64'h1 << w) - 64'h1);
    return {ok, !ok, !ok && !e[1], ok ? d : 64'h0};
  endfunction

  // Well-formed entry with reserved bits zero, as software must write it.
  // The descriptor address is always 64-byte aligned, one cache line each.
  function automatic logic [127:0] mk(input logic [1:0] t, input logic [1:0] q,
                                      input logic [15:0] s, input logic f,
                                      input logic [31:0] a);
    return {a, 12'h000, t, q, s, a[25:0], 14'h0000, 22'h00_0000, f, 1'b1};
  endfunction

  // One comparison; a mismatch is printed and counted at once.
  task automatic chk(input logic [66:0] got, input logic [66:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    chk({35'h0, bus_rdata}, {35'h0, exp});
  endtask

  task automatic set_entry(input logic [127:0] e);
    ent = e;
    for (int i = 0; i < 4; i++) bus_write(8'(4 * i), e[32 * i +: 32]);
  endtask

  task automatic set_haw(input logic [6:0] w);
    host_address_width = w;
    bus_write(OFS_HAW, {25'h000_0000, w});
  endtask

  // One request through the source model; the verdict lands one cycle later.
  task automatic send(input logic [15:0] r);
    logic [66:0] e;
    e = exp_resp(ent, host_address_width, r);
    @(posedge mclk);
    go <= 1'b1;
    go_rid <= r;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    #1;
    chk({63'h0, resp_valid, resp_accept, resp_block, resp_fault}, {63'h1, e[66:64]});
    chk({3'h0, resp_desc}, {3'h0, e[63:0]});
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch and ends the run.
  initial begin
    repeat (100000) @(posedge mclk);
    err_total++;
    finish_test();
  end

  // Ids around 16'h4A57: exact, bit 2, bits 1 and 2, bit 0, bit 3, bus bounds.
  logic [15:0] rids [8] = '{16'h4A57, 16'h4A53, 16'h4A51, 16'h4A56, 16'h4A5F,
                             16'h4900, 16'h57FF, 16'h5800};

  initial begin
    sys_rst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0000_0000;
    go = 1'b0;
    go_rid = 16'h0000;
    ent = 128'h0;
    host_address_width = 7'h40;
    lfsr = 32'hade5_8a4c;
    err_total = 0;
    n_checks = 0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    // Defaults after reset, an unmapped read, then a request to an absent entry.
    rd_chk(OFS_HAW, 32'h0000_0040);
    rd_chk(OFS_MASK, 32'h0000_0000);
    rd_chk(OFS_ENTRY3, 32'h0000_0000);
    rd_chk(8'h20, 32'h0000_0000);
    send(16'h1234);
    rd_chk(OFS_STATUS, 32'h0000_0006);
    $display("test reset done");
    // Every check type, qualifier and fault setting against the id table.
    for (int c = 0; c < 32; c++) begin
      lfsr = next_rand(lfsr);
      set_entry(mk(c[4:3], c[2:1], 16'h4A57, c[0], lfsr));
      for (int k = 0; k < 8; k++) send(rids[k]);
    end
    $display("test codes done");
    // Random entries, host widths and ids, reserved bits sometimes set.
    for (int n = 0; n < 60; n++) begin
      for (int w = 0; w < 4; w++) begin
        lfsr = next_rand(lfsr);
        rnd[32 * w +: 32] = lfsr;
      end
      if (rnd[2]) rnd[95:84] = 12'h000;
      if (rnd[3]) rnd[37:24] = 14'h0000;
      rnd[0] = rnd[0] | rnd[4];
      set_entry(rnd);
      set_haw(rnd[13] ? 7'h40 : 7'(32 + rnd[12:8]));
      send(rnd[79:64] ^ {rnd[7] ? rnd[111:104] : 8'h00, 5'h00, rnd[22:20]});
    end
    $display("test random done");
    // Sticky status, write-one-to-clear, mask and the interrupt level.
    bus_write(OFS_STATUS, 32'h0000_0007);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    set_entry(mk(2'h3, 2'h0, 16'h0000, 1'b1, 32'h0000_0000));
    send(16'h00A5);
    chk({66'h0, irq}, 67'h0);
    rd_chk(OFS_STATUS, 32'h0000_0002);
    rd_chk(OFS_LAST, 32'h0002_00A5);
    bus_write(OFS_MASK, 32'h0000_0002);
    @(posedge mclk);
    #1;
    chk({66'h0, irq}, 67'h1);
    bus_write(OFS_STATUS, 32'h0000_0002);
    @(posedge mclk);
    #1;
    chk({66'h0, irq}, 67'h0);
    $display("test interrupt done");
    finish_test();
  end
endmodule
